// ==== tpbls_pkg.sv ====
// Purpose: shared constants for the pattern sequencer and the array controller
// Assumes: 256 x 256 pixel array, 16 blocks of 16 rows, 4 segments of 4 rows
// Notes: one 64-bit word carries 64 pixels of a row; 4 words make a row
package tpbls_pkg;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          CYCLE_SEC     = 2;
  localparam int          CYCLE_CNT     = CLK_HZ * CYCLE_SEC;
  localparam int          NBLK          = 16;
  localparam int          WORD_W        = 64;
  localparam int          NCH           = 4;
  localparam int          LINK_W        = WORD_W * NCH;
  localparam logic [7:0]  XY_MAX        = 8'hff;
  localparam logic [3:0]  BEAT_LAST     = 4'hf;
  localparam logic [5:0]  SLOW_LAST     = 6'h3f;
  localparam logic [7:0]  DOT_PITCH     = 8'h0a;
  // load types on the link
  localparam logic [1:0]  LT_DATA       = 2'h0;
  localparam logic [1:0]  LT_CLEAR      = 2'h1;
  localparam logic [1:0]  LT_SET        = 2'h2;
  // reset modes
  localparam logic [2:0]  M_GLOBAL      = 3'h0;
  localparam logic [2:0]  M_SINGLE      = 3'h1;
  localparam logic [2:0]  M_CLEAR       = 3'h2;
  localparam logic [2:0]  M_SET         = 3'h3;
  localparam logic [2:0]  M_SLOW        = 3'h4;
  // patterns; the first eight form the cycle
  localparam logic [3:0]  P_ALL_ON      = 4'h0;
  localparam logic [3:0]  P_ALL_OFF     = 4'h1;
  localparam logic [3:0]  P_CHECK       = 4'h2;
  localparam logic [3:0]  P_GRID        = 4'h3;
  localparam logic [3:0]  P_DIAG_WE     = 4'h4;
  localparam logic [3:0]  P_DIAG_EW     = 4'h5;
  localparam logic [3:0]  P_HLINES      = 4'h6;
  localparam logic [3:0]  P_VLINES      = 4'h7;
  localparam logic [3:0]  P_SMALL_CHECK = 4'h8;
  localparam logic [3:0]  P_DOTS        = 4'h9;
  localparam logic [3:0]  P_INV_CHECK   = 4'ha;
  localparam logic [3:0]  P_NOISE       = 4'hb;
  localparam logic [3:0]  P_HLINE1      = 4'hc;
  localparam logic [3:0]  P_VLINE1      = 4'hd;
  localparam logic [3:0]  P_TOGGLE      = 4'he;
  // register map
  localparam logic [11:0] A_CTRL        = 12'h000;
  localparam logic [11:0] A_MASK        = 12'h004;
  localparam logic [11:0] A_STATUS      = 12'h008;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [15:0] MASK_RST      = 16'hffff;
  localparam int          C_EN          = 0;
  localparam int          C_CYC         = 1;
  localparam int          C_FLIP        = 2;
  localparam int          C_PAT         = 4;
  localparam int          C_MODE        = 8;
  localparam logic [63:0] NOISE_SEED    = 64'h9e37_79b9_7f4a_7c15;
endpackage : tpbls_pkg

// ==== tpbls_if.sv ====
// Purpose: link between pattern sequencer and micromirror array controller
// Assumes: both ends on pclk
// Notes: lane_data is four 64-bit channels, channel c in bits c*64 upward
`timescale 1ns/100ps
interface tpbls_if (input wire logic pclk);
  logic         array_load;
  logic [1:0]   load_type;
  logic [3:0]   load_block;
  logic         cmd_valid;
  logic         fast_mode;
  logic [1:0]   seg_code;
  logic [255:0] lane_data;
  logic         load_done;
  logic         block_reset_trigger;
  logic         reset_global;
  logic [3:0]   reset_block;
  modport dev (input load_done, output array_load, load_type, load_block, cmd_valid,
               fast_mode, seg_code, lane_data, block_reset_trigger, reset_global,
               reset_block);
  modport ctl (output load_done, input array_load, load_type, load_block, cmd_valid,
               fast_mode, seg_code, lane_data, block_reset_trigger, reset_global,
               reset_block);
endinterface : tpbls_if

// ==== tpbls_seq.sv ====
// Purpose: test pattern generator and block load sequencer, APB slave
// Assumes: controller pulses load_done once per block load
// Notes: settings are sampled at each frame start
//
// How it works
// - enable on sends patterns, off lets a frame finish once its first block load has begun, then sends nothing
// - cycle first eight patterns, 2 s each
// - flip reverses row order
// - all-on all ones, all-off all zeros
// - checkerboard squares 64 by 64
// - small checkerboard squares 32 by 32
// - inverting checkerboard is complement
// - dots every 10 pixels both ways
// - one-pixel rows alternate white, black
// - one-pixel columns alternate white, black
// - toggle alternates all-on and all-off
// - grid lights the outer border
// - global: load all enabled blocks first
// - global: one trigger resets all blocks
// - single: trigger after each block load done
// - clear load: no data, mirrors off
// - clear/set: load only, no command valid
// - set load: no data, mirrors on
// - slow: one channel, segments in series
// - slow: segments sent 3, 2, 1, 0
// - slow: trigger after all four segments
// - only blocks in enable mask used
`timescale 1ns/100ps
module tpbls_seq
  import tpbls_pkg::*;
#(
  parameter int CYC_CNT = CYCLE_CNT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  tpbls_if.dev             lnk
);
  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_LOAD, S_STREAM, S_WAIT, S_TRIG} tpbls_state_e;

  tpbls_state_e  st_r;
  logic [31:0]   ctrl_r;
  logic [15:0]   mask_r;
  logic [15:0]   fmask_r;
  logic [3:0]    pat_r;
  logic [2:0]    mode_r;
  logic          flip_r;
  logic          toggle_r;
  logic          any_r;
  logic [3:0]    blk_r;
  logic [3:0]    beat_r;
  logic [1:0]    seg_r;
  logic [2:0]    cyc_idx_r;
  logic [31:0]   cyc_cnt_r;
  logic [63:0]   noise_r;
  logic [255:0]  gen_w;

  // apb: one wait state so that every bus output comes from a flop
  wire acc      = psel & penable & ~pready;
  wire hit_ctrl = (paddr == A_CTRL);
  wire hit_mask = (paddr == A_MASK);
  wire hit_stat = (paddr == A_STATUS);
  wire hit      = hit_ctrl | hit_mask | hit_stat;
  wire wr_ok    = acc & pwrite & hit;
  wire [31:0] stat_w = {19'h00000, pat_r,
                        blk_r, 1'b0, mode_r, st_r != S_IDLE ? 1'b1 : 1'b0};
  wire [31:0] rd_w = hit_ctrl ? ctrl_r : hit_mask ? {16'h0000, mask_r} :
                     hit_stat ? stat_w : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_r  <= CTRL_RST;
      mask_r  <= MASK_RST;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= (acc & ~pwrite) ? rd_w : 32'h0000_0000;
      if (wr_ok && hit_ctrl) begin
        ctrl_r <= {20'h00000, 1'b0, pwdata[10:8], pwdata[7:4], 1'b0, pwdata[2:0]};
      end
      if (wr_ok && hit_mask) begin
        mask_r <= pwdata[15:0];
      end
    end
  end

  // cycle timer runs while cycling is on
  wire cyc_on   = ctrl_r[C_EN] & ctrl_r[C_CYC];
  wire cyc_tick = cyc_on && (cyc_cnt_r == 32'(CYC_CNT - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cnt_r <= 32'h0000_0000;
      cyc_idx_r <= 3'h0;
      noise_r   <= NOISE_SEED;
    end else begin
      cyc_cnt_r <= (!cyc_on || cyc_tick) ? 32'h0000_0000 : cyc_cnt_r + 32'h0000_0001;
      cyc_idx_r <= !cyc_on ? 3'h0 : cyc_tick ? cyc_idx_r + 3'h1 : cyc_idx_r;
      // xorshift gives 64 fresh bits every clock
      noise_r   <= noise_r ^ (noise_r << 13) ^ (noise_r >> 7) ^ (noise_r << 17);
    end
  end

  function automatic logic pix(input logic [3:0] p, input logic [7:0] x,
                               input logic [7:0] y, input logic tg, input logic nz);
    logic r;
    r = 1'b0;
    case (p)
      P_ALL_ON:      r = 1'b1;
      P_ALL_OFF:     r = 1'b0;
      P_CHECK:       r = x[6] ^ y[6];
      P_SMALL_CHECK: r = x[5] ^ y[5];
      P_INV_CHECK:   r = ~(x[6] ^ y[6]);
      P_DOTS:        r = (x % DOT_PITCH == 8'h00) && (y % DOT_PITCH == 8'h00);
      P_HLINE1:      r = ~y[0];
      P_VLINE1:      r = ~x[0];
      P_TOGGLE:      r = tg;
      P_GRID:        r = (x == 8'h00) || (x == XY_MAX) || (y == 8'h00) || (y == XY_MAX);
      P_DIAG_WE:     r = (x[3:0] == y[3:0]);
      P_DIAG_EW:     r = (4'(x[3:0] + y[3:0]) == 4'hf);
      P_HLINES:      r = (y[3:0] == 4'h0);
      P_VLINES:      r = (x[3:0] == 4'h0);
      P_NOISE:       r = nz;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : pix

  wire slow_w = (mode_r == M_SLOW);

  // one beat: row beat_r[3:2], word beat_r[1:0] of each segment
  always_comb begin
    gen_w = '0;
    for (int c = 0; c < NCH; c++) begin
      for (int i = 0; i < WORD_W; i++) begin
        logic [1:0] sg;
        logic [7:0] yr;
        logic [7:0] x;
        sg = slow_w ? seg_r : 2'(c);
        yr = {blk_r, sg, beat_r[3:2]};
        x  = {beat_r[1:0], 6'(i)};
        if (!slow_w || c == 0) begin
          gen_w[c*WORD_W + i] = pix(pat_r, x, flip_r ? XY_MAX - yr : yr, toggle_r,
                                    noise_r[(i + c*16) % WORD_W]);
        end
      end
    end
  end

  wire glob_w  = (mode_r == M_GLOBAL) || (mode_r == M_CLEAR) || (mode_r == M_SET);
  wire [3:0] pat_sel = ctrl_r[C_CYC] ? {1'b0, cyc_idx_r} : ctrl_r[C_PAT +: 4];
  wire [1:0] ltype_w = (mode_r == M_CLEAR) ? LT_CLEAR : (mode_r == M_SET) ? LT_SET : LT_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r                    <= S_IDLE;
      fmask_r                 <= 16'h0000;
      pat_r                   <= P_ALL_ON;
      mode_r                  <= M_GLOBAL;
      flip_r                  <= 1'b0;
      toggle_r                <= 1'b0;
      any_r                   <= 1'b0;
      blk_r                   <= 4'h0;
      beat_r                  <= 4'h0;
      seg_r                   <= 2'h0;
      lnk.array_load          <= 1'b0;
      lnk.load_type           <= LT_DATA;
      lnk.load_block          <= 4'h0;
      lnk.cmd_valid           <= 1'b0;
      lnk.fast_mode           <= 1'b1;
      lnk.seg_code            <= 2'h0;
      lnk.lane_data           <= '0;
      lnk.block_reset_trigger <= 1'b0;
      lnk.reset_global        <= 1'b0;
      lnk.reset_block         <= 4'h0;
    end else begin
      lnk.array_load          <= 1'b0;
      lnk.cmd_valid           <= 1'b0;
      lnk.block_reset_trigger <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (ctrl_r[C_EN]) begin
            // settings latched here hold for the whole frame
            pat_r    <= pat_sel;
            flip_r   <= ctrl_r[C_FLIP];
            mode_r   <= ctrl_r[C_MODE +: 3];
            fmask_r  <= mask_r;
            toggle_r <= ~toggle_r;
            any_r    <= 1'b0;
            blk_r    <= 4'h0;
            st_r     <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (!ctrl_r[C_EN] && !any_r) begin
            st_r <= S_IDLE;
          end else if (fmask_r[blk_r]) begin
            lnk.array_load <= 1'b1;
            lnk.load_type  <= ltype_w;
            lnk.load_block <= blk_r;
            lnk.fast_mode  <= ~slow_w;
            seg_r          <= 2'h3;
            beat_r         <= 4'h0;
            st_r           <= S_LOAD;
          end else if (blk_r == 4'(NBLK - 1)) begin
            st_r <= (glob_w && any_r) ? S_TRIG : S_IDLE;
          end else begin
            blk_r <= blk_r + 4'h1;
          end
        end
        S_LOAD: begin
          // clear and set carry no payload
          st_r <= (ltype_w == LT_DATA) ? S_STREAM : S_WAIT;
        end
        S_STREAM: begin
          lnk.cmd_valid <= 1'b1;
          lnk.lane_data <= gen_w;
          lnk.seg_code  <= seg_r;
          beat_r        <= beat_r + 4'h1;
          if (beat_r == BEAT_LAST) begin
            if (slow_w && seg_r != 2'h0) begin
              seg_r <= seg_r - 2'h1;
            end else begin
              st_r <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (lnk.load_done) begin
            any_r <= 1'b1;
            if (glob_w) begin
              // global: next block before any reset
              st_r <= (blk_r == 4'(NBLK - 1)) ? S_TRIG : S_SCAN;
              if (blk_r != 4'(NBLK - 1)) begin
                blk_r <= blk_r + 4'h1;
              end
            end else begin
              st_r <= S_TRIG;
            end
          end
        end
        S_TRIG: begin
          lnk.block_reset_trigger <= 1'b1;
          lnk.reset_global        <= glob_w;
          lnk.reset_block         <= blk_r;
          if (glob_w || blk_r == 4'(NBLK - 1)) begin
            st_r <= S_IDLE;
          end else begin
            blk_r <= blk_r + 4'h1;
            st_r  <= S_SCAN;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule : tpbls_seq

// ==== tpbls_ctl.sv ====
// Purpose: micromirror array controller end: stores block loads, applies resets
// Assumes: sequencer streams beats back to back after a data load
// Notes: clear and set are kept as a per-block fill flag, not written out
`timescale 1ns/100ps
module tpbls_ctl
  import tpbls_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  tpbls_if.ctl             lnk,
  input  wire logic [7:0]  rd_row,
  output logic [255:0]     rd_data,
  output logic             applied,
  output logic [15:0]      applied_mask
);
  logic [63:0] mem0 [256];
  logic [63:0] mem1 [256];
  logic [63:0] mem2 [256];
  logic [63:0] mem3 [256];
  logic [15:0] fill_r;
  logic [15:0] fill_val_r;
  logic [3:0]  blk_r;
  logic [5:0]  cnt_r;
  logic        fast_r;

  wire [1:0] wseg  = lnk.fast_mode ? 2'h0 : lnk.seg_code;
  wire [7:0] widx  = {blk_r, cnt_r[3:0]};
  wire       wlast = fast_r ? (cnt_r[3:0] == BEAT_LAST) : (cnt_r == SLOW_LAST);

  always_ff @(posedge pclk) begin
    if (lnk.cmd_valid) begin
      if (lnk.fast_mode || wseg == 2'h0) mem0[widx] <= lnk.lane_data[63:0];
      if (lnk.fast_mode) begin
        mem1[widx] <= lnk.lane_data[127:64];
        mem2[widx] <= lnk.lane_data[191:128];
        mem3[widx] <= lnk.lane_data[255:192];
      end else begin
        // slow: everything rides on channel 0, segment code steers it
        if (wseg == 2'h1) mem1[widx] <= lnk.lane_data[63:0];
        if (wseg == 2'h2) mem2[widx] <= lnk.lane_data[63:0];
        if (wseg == 2'h3) mem3[widx] <= lnk.lane_data[63:0];
      end
    end
  end

  wire [7:0]  ridx = {rd_row[7:4], rd_row[1:0], 2'h0};
  wire [63:0] rw0  = rd_row[3:2] == 2'h0 ? mem0[ridx] : rd_row[3:2] == 2'h1 ? mem1[ridx] :
                     rd_row[3:2] == 2'h2 ? mem2[ridx] : mem3[ridx];
  wire [63:0] rw1  = rd_row[3:2] == 2'h0 ? mem0[ridx + 8'h01] : rd_row[3:2] == 2'h1 ?
                     mem1[ridx + 8'h01] : rd_row[3:2] == 2'h2 ? mem2[ridx + 8'h01] :
                     mem3[ridx + 8'h01];
  wire [63:0] rw2  = rd_row[3:2] == 2'h0 ? mem0[ridx + 8'h02] : rd_row[3:2] == 2'h1 ?
                     mem1[ridx + 8'h02] : rd_row[3:2] == 2'h2 ? mem2[ridx + 8'h02] :
                     mem3[ridx + 8'h02];
  wire [63:0] rw3  = rd_row[3:2] == 2'h0 ? mem0[ridx + 8'h03] : rd_row[3:2] == 2'h1 ?
                     mem1[ridx + 8'h03] : rd_row[3:2] == 2'h2 ? mem2[ridx + 8'h03] :
                     mem3[ridx + 8'h03];
  wire        rfill = fill_r[rd_row[7:4]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_r        <= 16'hffff;
      fill_val_r    <= 16'h0000;
      blk_r         <= 4'h0;
      cnt_r         <= 6'h00;
      fast_r        <= 1'b1;
      lnk.load_done <= 1'b0;
      rd_data       <= '0;
      applied       <= 1'b0;
      applied_mask  <= 16'h0000;
    end else begin
      lnk.load_done <= 1'b0;
      applied       <= lnk.block_reset_trigger;
      rd_data       <= rfill ? {256{fill_val_r[rd_row[7:4]]}} : {rw3, rw2, rw1, rw0};
      if (lnk.array_load) begin
        blk_r  <= lnk.load_block;
        cnt_r  <= 6'h00;
        fast_r <= lnk.fast_mode;
        fill_r[lnk.load_block] <= (lnk.load_type != LT_DATA);
        fill_val_r[lnk.load_block] <= (lnk.load_type == LT_SET);
        lnk.load_done <= (lnk.load_type != LT_DATA);
      end else if (lnk.cmd_valid) begin
        cnt_r         <= cnt_r + 6'h01;
        lnk.load_done <= wlast;
      end
      if (lnk.block_reset_trigger) begin
        applied_mask <= lnk.reset_global ? 16'hffff : 16'(16'h0001 << lnk.reset_block);
      end
    end
  end
endmodule : tpbls_ctl

// ==== tpbls_link_monitor.sv ====
// Purpose: link timing checks between sequencer and array controller
// Assumes: both ends on pclk, presetn async active low
// Notes: helper logic counts data beats of the load in flight
`timescale 1ns/100ps
module tpbls_link_monitor
  import tpbls_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       array_load,
  input wire logic [1:0] load_type,
  input wire logic [3:0] load_block,
  input wire logic       cmd_valid,
  input wire logic       fast_mode,
  input wire logic [1:0] seg_code,
  input wire logic       load_done,
  input wire logic       block_reset_trigger,
  input wire logic       reset_global,
  input wire logic [3:0] reset_block
);
  logic [6:0] beat_r;
  logic       data_r;
  logic       busy_r;
  wire        data_ld = array_load && (load_type == LT_DATA);
  wire        fill_ld = array_load && (load_type != LT_DATA);
  wire        loc_trg = block_reset_trigger && !reset_global;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_r <= 7'h00;
      data_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      beat_r <= array_load ? 7'h00 : beat_r + {6'h00, cmd_valid};
      data_r <= array_load ? data_ld : data_r;
      busy_r <= array_load || (busy_r && !load_done);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_beats8;
    cmd_valid [*8];
  endsequence
  sequence s_fast_load;
    !cmd_valid ##1 s_beats8 ##1 s_beats8 ##1 load_done;
  endsequence
  property p_fast_walk; data_ld && fast_mode |=> s_fast_load; endproperty
  property p_fill_nocmd; fill_ld |-> !cmd_valid [*3]; endproperty
  property p_fill_done; fill_ld |=> load_done; endproperty
  property p_beats; load_done && data_r |-> beat_r == (fast_mode ? 7'h10 : 7'h40); endproperty
  property p_slow_first; data_ld && !fast_mode |-> ##2 (cmd_valid && seg_code == 2'h3); endproperty
  property p_slow_desc;
    cmd_valid && $past(cmd_valid) && !fast_mode && seg_code != $past(seg_code)
      |-> seg_code == $past(seg_code) - 2'h1;
  endproperty
  property p_trig_quiet; block_reset_trigger |-> !busy_r && !array_load; endproperty
  property p_single_trig; loc_trg |-> $past(load_done) || $past(load_done, 2); endproperty
  property p_trig_blk; loc_trg |-> reset_block == load_block; endproperty
  a_fast_walk: assert property (p_fast_walk) else $error("fast load walk broken");
  a_fill_nocmd: assert property (p_fill_nocmd) else $error("beat on fill load");
  a_fill_done: assert property (p_fill_done) else $error("fill load not done");
  a_beats: assert property (p_beats) else $error("wrong beat count");
  a_slow_first: assert property (p_slow_first) else $error("slow load not seg 3");
  a_slow_desc: assert property (p_slow_desc) else $error("segment order");
  a_trig_quiet: assert property (p_trig_quiet) else $error("trigger in load");
  a_single_trig: assert property (p_single_trig) else $error("trigger early");
  a_trig_blk: assert property (p_trig_blk) else $error("trigger block wrong");
endmodule : tpbls_link_monitor

// ==== tb_top.sv ====
// Purpose: both ends joined, driven over APB, array read back
// Assumes: short cycle count parameter
// Notes: pattern phase of checkers and line patterns is not fixed
`timescale 1ns/100ps
module tb_top
  import tpbls_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, applied, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdv;
  logic [7:0]   rd_row, seen;
  logic [255:0] rd_data, ex, ck_row;
  logic [15:0]  applied_mask, acc_mask, acc_blk;
  int           n_errors, comparisons, n_app, n_load;
  logic [12:0]  rows [14] = '{{P_ALL_ON, 9'h007}, {P_ALL_OFF, 9'h0c8}, {P_CHECK, 9'h046},
    {P_CHECK, 9'h000}, {P_INV_CHECK, 9'h000}, {P_SMALL_CHECK, 9'h028}, {P_DOTS, 9'h014},
    {P_DOTS, 9'h015}, {P_DOTS, 9'h105}, {P_DOTS, 9'h100}, {P_HLINE1, 9'h003},
    {P_VLINE1, 9'h009}, {P_GRID, 9'h000}, {P_GRID, 9'h080}};
  tpbls_if u_tpbls_if (.pclk(pclk));
  tpbls_seq #(.CYC_CNT(60)) u_tpbls_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .lnk(u_tpbls_if.dev));
  tpbls_ctl u_tpbls_ctl (.pclk(pclk), .presetn(presetn), .lnk(u_tpbls_if.ctl),
    .rd_row(rd_row), .rd_data(rd_data), .applied(applied), .applied_mask(applied_mask));
  tpbls_link_monitor u_tpbls_link_monitor (.pclk(pclk), .presetn(presetn),
    .array_load(u_tpbls_if.array_load), .load_type(u_tpbls_if.load_type),
    .load_block(u_tpbls_if.load_block), .cmd_valid(u_tpbls_if.cmd_valid),
    .fast_mode(u_tpbls_if.fast_mode), .seg_code(u_tpbls_if.seg_code),
    .load_done(u_tpbls_if.load_done), .block_reset_trigger(u_tpbls_if.block_reset_trigger),
    .reset_global(u_tpbls_if.reset_global), .reset_block(u_tpbls_if.reset_block));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (applied === 1'b1) begin
      n_app++;
      acc_mask |= applied_mask;
    end
    if (u_tpbls_if.array_load === 1'b1) begin
      n_load++;
      acc_blk |= 16'h0001 << u_tpbls_if.load_block;
    end
  end
  task automatic fail(input string m);
    n_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask : chk32
  task automatic chk256(input logic [255:0] g, input logic [255:0] e, input string m);
    comparisons++;
    if (g !== e) fail(m);
  endtask : chk256
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // enable until the first reset pulse, then stop at the frame boundary and wait for idle
  task automatic frame(input logic [3:0] p, input logic f, input logic [2:0] md,
                       input logic [15:0] mk);
    int n;
    n = 0;
    apb(1'b1, A_MASK, {16'h0000, mk});
    apb(1'b1, A_CTRL, {21'h000000, md, p, 1'b0, f, 2'h1});
    while (applied !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b1, A_CTRL, 32'h0000_0000);
    do begin
      apb(1'b0, A_STATUS, 32'h0000_0000);
      n++;
    end while (rdv[0] !== 1'b0 && n < 20000);
    if (n >= 20000) fail("frame hang");
  endtask : frame
  task automatic rd(input logic [7:0] y);
    @(posedge pclk);
    rd_row <= y;
    repeat (2) @(posedge pclk);
    #1;
  endtask : rd
  function automatic logic [255:0] exp_row(input logic [3:0] p, input logic [7:0] y);
    logic [255:0] v;
    for (int x = 0; x < 256; x++) begin
      case (p)
        P_ALL_ON:      v[x] = 1'b1;
        P_CHECK:       v[x] = ((x / 64) % 2) != ((y / 64) % 2);
        P_SMALL_CHECK: v[x] = ((x / 32) % 2) != ((y / 32) % 2);
        P_DOTS:        v[x] = (x % DOT_PITCH == 0) && (y % DOT_PITCH == 0);
        P_HLINE1:      v[x] = y[0];
        P_VLINE1:      v[x] = x[0];
        P_GRID:        v[x] = x == 0 || x == 255 || y == 8'h00 || y == 8'hff;
        default:       v[x] = 1'b0;
      endcase
    end
    return v;
  endfunction : exp_row
  initial begin
    #500_000;
    fail("timeout");
    close_out();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, rd_row} = '0;
    {n_errors, comparisons, n_app, n_load, acc_mask, acc_blk, seen} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0000_0000);
    chk32(rdv, CTRL_RST, "ctrl reset value");
    apb(1'b0, A_MASK, 32'h0000_0000);
    chk32(rdv, {16'h0000, MASK_RST}, "mask reset value");
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk32({rdv[30:0], err}, 32'h0000_0001, "unmapped read");
    apb(1'b1, A_STATUS, 32'hffff_ffff);
    repeat (300) @(posedge pclk);
    chk32({err, n_load[30:0]}, 32'h0000_0000, "load while disabled");
    for (int i = 0; i < 14; i++) begin
      if (i == 0 || rows[i][12:8] != rows[i-1][12:8])
        frame(rows[i][12:9], rows[i][8], M_GLOBAL, 16'hffff);
      rd(rows[i][7:0]);
      ex = exp_row(rows[i][12:9], rows[i][8] ? 8'hff - rows[i][7:0] : rows[i][7:0]);
      if (rows[i][12:9] inside {P_CHECK, P_SMALL_CHECK, P_HLINE1, P_VLINE1} &&
          rd_data[0] !== ex[0]) ex = ~ex;
      if (rows[i][12:9] == P_INV_CHECK) ex = ~ck_row;
      if (rows[i][12:9] == P_CHECK) ck_row = rd_data;
      chk256(rd_data, ex, "row");
    end
    chk32({16'h0000, applied_mask}, 32'h0000_ffff, "global reset mask");
    frame(P_ALL_OFF, 1'b0, M_GLOBAL, 16'hffff);
    frame(P_ALL_OFF, 1'b0, M_SET, 16'h0002);
    rd(8'h10);
    chk256(rd_data, {256{1'b1}}, "set block");
    rd(8'h00);
    chk256(rd_data, '0, "unmasked block");
    frame(P_ALL_ON, 1'b0, M_GLOBAL, 16'hffff);
    frame(P_ALL_ON, 1'b0, M_CLEAR, 16'h0001);
    rd(8'h0f);
    chk256(rd_data, '0, "clear block");
    rd(8'h10);
    chk256(rd_data, {256{1'b1}}, "unmasked block");
    // single then slow, two far blocks; slow uses another pattern so block 15 changes
    for (int k = 0; k < 2; k++) begin
      #1;
      {n_app, acc_mask, acc_blk} = '0;
      frame(k ? P_GRID : P_DOTS, 1'b0, k ? M_SLOW : M_SINGLE, 16'h8001);
      chk32(n_app, 32'h0000_0002, "one trigger per block");
      chk32({acc_mask, acc_blk}, 32'h8001_8001, "blocks used");
      rd(8'hf0);
      chk256(rd_data, exp_row(k ? P_GRID : P_DOTS, 8'hf0), "block data");
    end
    // one single-mode frame per call, so the toggle must flip between the two
    for (int k = 0; k < 2; k++) begin
      frame(P_TOGGLE, 1'b0, M_SINGLE, 16'h0001);
      rd(8'h00);
      chk256(rd_data, k ? ~ck_row : {256{rd_data[0]}}, "toggle row");
      ck_row = rd_data;
    end
    frame(P_NOISE, 1'b0, M_SINGLE, 16'h0001);
    rd(8'h00);
    chk32({31'h0, rd_data != '0 && rd_data != '1}, 32'h0000_0001, "noise flat");
    apb(1'b1, A_CTRL, {21'h000000, M_GLOBAL, P_DOTS, 4'h3});
    repeat (4) begin
      while (applied !== 1'b1) @(posedge pclk);
      apb(1'b0, A_STATUS, 32'h0000_0000);
      seen |= 8'h01 << rdv[11:9];
      chk32({31'h0, rdv[12]}, 32'h0000_0000, "cycle pattern range");
    end
    chk32({31'h0, $countones(seen) > 1}, 32'h0000_0001, "cycle steps");
    close_out();
  end
endmodule : tb_top
